// *** acmp_regs.sv ***
// Purpose: control, startup and interrupt mask logic for two comparators
// Assumes: classic wishbone, ack one cycle after request, synchronous reset
// Notes: comparator interface clock arrives as a one-cycle enable
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module acmp_regs
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic if_clk_en_in,
    input wire logic [2:0] cmp_event_in,
    input wire logic [1:0] cmp_level_in,
    output logic [4:0] enables_out,
    output logic [1:0] ready_out,
    output logic [1:0] event_on_out,
    output logic irq_out
);
    // ****************************************************
    // bus decode
    // ****************************************************
    logic req;
    logic wr;
    logic [31:0] wd;
    logic [4:0] wd5;
    assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr = req && wb_we_in;
    assign wd = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                 {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}} & wb_dat_in;
    // write data only while a write is taken, zero otherwise
    assign wd5 = wr ? wd[4:0] : 5'h00;

    // every input is an argument so the assigns stay sensitive to it
    function automatic logic [4:0] wr5(input logic [7:0] adr,
                                       input logic [7:0] ofs,
                                       input logic [4:0] data);
        wr5 = (adr == ofs) ? data : 5'h00;
    endfunction

    logic [4:0] on_w;
    logic [4:0] off_w;
    logic [4:0] ion_w;
    logic [4:0] ioff_w;
    logic [4:0] clr_w;
    logic [4:0] eon5;
    logic [4:0] eoff5;
    logic [1:0] eon_w;
    logic [1:0] eoff_w;
    assign on_w = wr5(wb_adr_in, acmp_pkg::ON_OFS, wd5);
    assign off_w = wr5(wb_adr_in, acmp_pkg::OFF_OFS, wd5);
    assign ion_w = wr5(wb_adr_in, acmp_pkg::IRQ_ON_OFS, wd5);
    assign ioff_w = wr5(wb_adr_in, acmp_pkg::IRQ_OFF_OFS, wd5);
    assign clr_w = wr5(wb_adr_in, acmp_pkg::CLEAR_OFS, wd5);
    assign eon5 = wr5(wb_adr_in, acmp_pkg::EVT_ON_OFS, wd5);
    assign eoff5 = wr5(wb_adr_in, acmp_pkg::EVT_OFF_OFS, wd5);
    assign eon_w = eon5[1:0];
    assign eoff_w = eoff5[1:0];

    // ****************************************************
    // enable state
    // ****************************************************
    acmp_pkg::enables_t en_reg;
    logic a_start;
    logic b_start;
    assign a_start = !en_reg.a_on && (on_w[acmp_pkg::BIT_A]
                     || on_w[acmp_pkg::BIT_W]);
    assign b_start = !en_reg.b_on && (on_w[acmp_pkg::BIT_B]
                     || on_w[acmp_pkg::BIT_W]);

    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
            en_reg <= '0;
        else
        begin
            // zero bits leave state alone; off wins over on
            if (on_w[acmp_pkg::BIT_A] || on_w[acmp_pkg::BIT_W])
                en_reg.a_on <= 1'b1;
            if (on_w[acmp_pkg::BIT_B] || on_w[acmp_pkg::BIT_W])
                en_reg.b_on <= 1'b1;
            if (on_w[acmp_pkg::BIT_W])
                en_reg.w_on <= 1'b1;
            if (on_w[acmp_pkg::BIT_ACMP] || on_w[acmp_pkg::BIT_W])
                en_reg.a_cmp <= 1'b1;
            if (on_w[acmp_pkg::BIT_BCMP] || on_w[acmp_pkg::BIT_W])
                en_reg.b_cmp <= 1'b1;
            if (off_w[acmp_pkg::BIT_A])
                en_reg.a_on <= 1'b0;
            if (off_w[acmp_pkg::BIT_B])
                en_reg.b_on <= 1'b0;
            if (off_w[acmp_pkg::BIT_W])
                en_reg.w_on <= 1'b0;
            if (off_w[acmp_pkg::BIT_ACMP] || off_w[acmp_pkg::BIT_W])
                en_reg.a_cmp <= 1'b0;
            if (off_w[acmp_pkg::BIT_BCMP] || off_w[acmp_pkg::BIT_W])
                en_reg.b_cmp <= 1'b0;
        end
    end

    // ****************************************************
    // startup delay
    // ****************************************************
    logic [acmp_pkg::STARTUP_W-1:0] delay_reg;
    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
            delay_reg <= acmp_pkg::STARTUP_RESET;
        else if (wr && wb_adr_in == acmp_pkg::STARTUP_OFS)
            delay_reg <= wd[acmp_pkg::STARTUP_W-1:0];
    end

    logic [1:0] on_now;
    logic [1:0] start_now;
    logic [1:0] stop_now;
    logic [1:0] rdy_reg;
    logic [1:0] delay_done;
    assign on_now = {en_reg.b_on, en_reg.a_on};
    assign start_now = {b_start, a_start};
    // a turn-off in the same cycle must not let ready rise
    assign stop_now = {off_w[acmp_pkg::BIT_B], off_w[acmp_pkg::BIT_A]};

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_startup
            logic [acmp_pkg::STARTUP_W-1:0] cnt_reg;
            logic done_reg;
            // counts interface clock periods after each switch-on
            always_ff @(posedge mclk_in)
            begin
                if (!nrst_in || start_now[g])
                    cnt_reg <= '0;
                else if (on_now[g] && !done_reg && if_clk_en_in
                         && cnt_reg < delay_reg)
                    cnt_reg <= cnt_reg + 1'b1;
            end
            always_ff @(posedge mclk_in)
            begin
                if (!nrst_in || start_now[g] || stop_now[g] || !on_now[g])
                    done_reg <= 1'b0;
                else if (cnt_reg >= delay_reg)
                    done_reg <= 1'b1;
            end
            assign rdy_reg[g] = done_reg;
            assign delay_done[g] = on_now[g] && !done_reg && !start_now[g]
                                   && !stop_now[g] && cnt_reg >= delay_reg;
        end
    endgenerate

    // ****************************************************
    // status flags and mask
    // ****************************************************
    logic [4:0] mask_reg;
    logic [4:0] pend_reg;
    logic [4:0] set_ev;
    logic [1:0] evt_reg;
    // compare events only count once the comparison is active
    assign set_ev = {delay_done[1], delay_done[0],
                     cmp_event_in[2] && en_reg.w_on && &rdy_reg,
                     cmp_event_in[1] && en_reg.b_cmp && rdy_reg[1],
                     cmp_event_in[0] && en_reg.a_cmp && rdy_reg[0]};

    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
            mask_reg <= acmp_pkg::MASK_RESET;
        else
            mask_reg <= (mask_reg | ion_w) & ~ioff_w;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
            pend_reg <= '0;
        else
            pend_reg <= (pend_reg & ~clr_w) | set_ev;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
            evt_reg <= acmp_pkg::EVT_RESET;
        else
            evt_reg <= (evt_reg | eon_w) & ~eoff_w;
    end

    // ****************************************************
    // outputs
    // ****************************************************
    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
        begin
            irq_out <= 1'b0;
            enables_out <= '0;
            ready_out <= '0;
            event_on_out <= '0;
        end
        else
        begin
            irq_out <= |(pend_reg & mask_reg);
            enables_out <= en_reg;
            ready_out <= rdy_reg;
            event_on_out <= evt_reg;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
        end
        else
        begin
            wb_ack_out <= req;
            wb_dat_out <= '0;
            if (req && !wb_we_in)
            begin
                unique case (wb_adr_in)
                    acmp_pkg::STARTUP_OFS:
                        wb_dat_out <= {22'h0, delay_reg};
                    acmp_pkg::MASK_OFS:
                        wb_dat_out <= {27'h0, mask_reg};
                    acmp_pkg::EVT_VIEW_OFS:
                        wb_dat_out <= {30'h0, evt_reg};
                    acmp_pkg::STATUS_OFS:
                        wb_dat_out <= {5'h0, &rdy_reg, rdy_reg, 5'h0,
                                       cmp_level_in[1:0] == 2'h3,
                                       cmp_level_in, 3'h0, en_reg.b_cmp,
                                       en_reg.a_cmp, en_reg.w_on,
                                       en_reg.b_on, en_reg.a_on,
                                       3'h0, pend_reg};
                    default:
                        wb_dat_out <= '0;
                endcase
            end
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    property p_win_on;
        @(posedge mclk_in) disable iff (!nrst_in)
        on_w[acmp_pkg::BIT_W] && off_w == 5'h00 |=> en_reg == 5'h1f;
    endproperty
    a_win_on: assert property (p_win_on) else $error("window on");

    property p_win_off;
        @(posedge mclk_in) disable iff (!nrst_in)
        off_w[acmp_pkg::BIT_W] |=> !en_reg.a_cmp && !en_reg.b_cmp
                                   && !en_reg.w_on;
    endproperty
    a_win_off: assert property (p_win_off) else $error("window off");

    property p_a_off;
        @(posedge mclk_in) disable iff (!nrst_in)
        off_w[acmp_pkg::BIT_A] |=> !en_reg.a_on ##1 !rdy_reg[0];
    endproperty
    a_a_off: assert property (p_a_off) else $error("a off");

    property p_mask;
        @(posedge mclk_in) disable iff (!nrst_in)
        ion_w != 5'h00 && ioff_w == 5'h00 |=> (mask_reg & $past(ion_w))
                                            == $past(ion_w);
    endproperty
    a_mask: assert property (p_mask) else $error("mask set");

    property p_unmask;
        @(posedge mclk_in) disable iff (!nrst_in)
        ioff_w != 5'h00 |=> (mask_reg & $past(ioff_w)) == 5'h00;
    endproperty
    a_unmask: assert property (p_unmask) else $error("mask clr");

    property p_irq;
        @(posedge mclk_in) disable iff (!nrst_in)
        |(pend_reg & mask_reg) |=> irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("irq");

    property p_ready;
        @(posedge mclk_in) disable iff (!nrst_in)
        $rose(rdy_reg[0]) |-> en_reg.a_on && pend_reg[acmp_pkg::BIT_ACMP];
    endproperty
    a_ready: assert property (p_ready) else $error("ready");

    sequence s_start_a;
        a_start;
    endsequence
    property p_restart;
        @(posedge mclk_in) disable iff (!nrst_in)
        s_start_a |=> !rdy_reg[0];
    endproperty
    a_restart: assert property (p_restart) else $error("restart");

    property p_evt;
        @(posedge mclk_in) disable iff (!nrst_in)
        eon_w[1] && !eoff_w[1] |=> ##1 event_on_out[1];
    endproperty
    a_evt: assert property (p_evt) else $error("event on");

    property p_wo_read;
        @(posedge mclk_in) disable iff (!nrst_in)
        req && !wb_we_in && wb_adr_in == acmp_pkg::IRQ_ON_OFS
        |=> wb_ack_out && wb_dat_out == 32'h0;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("wo read");
endmodule

// *** acmp_pkg.sv ***
// Purpose: constants and types for the comparator control register bank
// Assumes: 32-bit classic wishbone slave, one 10 MHz clock
// Notes: offsets are byte addresses
//
// Summary of operation
// - writing one to an enable bit turns on that comparator or comparison
// - window enable also turns on both comparators and both comparisons
// - turn-off register bits 0 and 1 switch off comparator a and b
// - turn-off bits 3 and 4 stop comparison a and b
// - turn-off bit 2 stops window and clears both comparison enables
// - startup count is read/write; delay is count times interface clock period
// - after a comparator turns on, its comparison waits out the delay
// - ones written to irq-on register set matching mask bits
// - ones written to irq-off register clear matching mask bits
// - mask view resets to zero and shows enabled sources
// - mask layout: a, b, window, a startup, b startup at bits 0..4
// - comparator a and b irq enables gate their condition-selected irqs
// - window irq enable at bit 2 gates the window irq
// - event-on bit 1 enables event output one; zero does nothing
// - ready sets only when comparator is on and delay elapsed
// - startup flag goes pending when the startup delay ends
// - status-clear ones clear flags and withdraw the interrupt request
// - event-off bit 1 disables event output one
package acmp_pkg;
    localparam logic [7:0] ON_OFS = 8'h1c;
    localparam logic [7:0] OFF_OFS = 8'h20;
    localparam logic [7:0] STARTUP_OFS = 8'h24;
    localparam logic [7:0] IRQ_ON_OFS = 8'h28;
    localparam logic [7:0] IRQ_OFF_OFS = 8'h2c;
    localparam logic [7:0] MASK_OFS = 8'h30;
    localparam logic [7:0] EVT_ON_OFS = 8'h34;
    localparam logic [7:0] EVT_OFF_OFS = 8'h38;
    localparam logic [7:0] EVT_VIEW_OFS = 8'h3c;
    localparam logic [7:0] STATUS_OFS = 8'h40;
    localparam logic [7:0] CLEAR_OFS = 8'h44;
    localparam int BIT_A = 0;
    localparam int BIT_B = 1;
    localparam int BIT_W = 2;
    localparam int BIT_ACMP = 3;
    localparam int BIT_BCMP = 4;
    localparam int STARTUP_W = 10;
    localparam logic [9:0] STARTUP_RESET = 10'h000;
    localparam logic [4:0] MASK_RESET = 5'h00;
    localparam logic [1:0] EVT_RESET = 2'h0;
    typedef struct packed {
        logic a_on;
        logic b_on;
        logic w_on;
        logic a_cmp;
        logic b_cmp;
    } enables_t;
endpackage

// *** acmp_far.sv ***
// Purpose: far-side model of the two comparators
// Assumes: interface clock enable every fourth bus clock
// Notes: levels toggle each cycle so stale values never look settled
`timescale 1ns/1ps
module acmp_far
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [2:0] fire_in,
    output logic if_clk_en_out,
    output logic [2:0] cmp_event_out,
    output logic [1:0] cmp_level_out
);
    // ****************************************
    // interface clock and comparator outputs
    // ****************************************
    logic [1:0] div_reg;
    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    end
    always_ff @(posedge mclk_in)
    begin
        if_clk_en_out <= (div_reg == 2'h3);
        cmp_event_out <= fire_in;
        cmp_level_out <= {div_reg[0], ~div_reg[0]};
    end
endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the comparator control registers
// Assumes: one bus request at a time
// Notes: a monitor checks read data against a queue of expectations
`timescale 1ns/1ps
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    n_fail++; $display("unexpected %s exp %h got %h", nm, e, s); end end
module tb_top;
    // ****************************************
    // signals and instances
    // ****************************************
    localparam int DELAY_V = 6;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat, d, d2, me, mm;
    logic ack, irq, if_en;
    logic [4:0] en_o;
    logic [4:0] en_r;
    logic [4:0] en_x = 5'h00;
    logic [4:0] mk_x = 5'h00;
    logic [1:0] rdy, evo, lvl;
    logic [2:0] ev;
    logic [2:0] fire = 3'h0;
    logic [31:0] eq[$];
    logic [31:0] mq[$];
    logic [7:0] ro[8] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34,
        8'hfc};
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n, p;
    always #50 mclk_in = ~mclk_in;
    acmp_regs u_acmp_regs (.mclk_in(mclk_in), .nrst_in(nrst_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .if_clk_en_in(if_en), .cmp_event_in(ev),
        .cmp_level_in(lvl), .enables_out(en_o), .ready_out(rdy),
        .event_on_out(evo), .irq_out(irq));
    acmp_far u_acmp_far (.mclk_in(mclk_in), .nrst_in(nrst_in),
        .fire_in(fire), .if_clk_en_out(if_en), .cmp_event_out(ev),
        .cmp_level_out(lvl));
    // ****************************************
    // bus tasks, monitor and verdict
    // ****************************************
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] v);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= v;
        sel <= 4'hf;
        do
        begin
            @(posedge mclk_in);
        end
        while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        eq.push_back(e & m);
        mq.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk_in)
    begin
        cycles++;
        if (ack === 1'b1 && we === 1'b0 && eq.size() > 0)
        begin
            me = eq.pop_front();
            mm = mq.pop_front();
            `CHK("rdata", me, rdat & mm)
        end
        if (cycles == 20000)
        begin
            n_fail++;
            results();
        end
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        void'($urandom(31875));
        repeat (4) @(posedge mclk_in);
        nrst_in <= 1'b1;
        @(posedge mclk_in);
        foreach (ro[i])
            rd(ro[i], 32'h0, 32'hffffffff);
        for (int i = 0; i < 8; i++)
        begin
            d = $urandom;
            if (i == 0)
                d[2] = 1'b1;
            bus(1'b1, 8'h1c, d);
            en_x |= d[2] ? 5'h1f : d[4:0];
            rd(8'h40, {19'h0, en_x, 8'h0}, 32'h41f00);
            en_r = {en_x[0], en_x[1], en_x[2], en_x[3], en_x[4]};
            `CHK("enables", en_r, en_o)
            d = $urandom;
            if (i == 1)
                d[2] = 1'b1;
            bus(1'b1, 8'h20, d);
            en_x &= ~(d[4:0] | (d[2] ? 5'h18 : 5'h00));
            rd(8'h40, {19'h0, en_x, 8'h0}, 32'h1f00);
        end
        for (int i = 0; i < 6; i++)
        begin
            d = $urandom;
            d2 = $urandom;
            bus(1'b1, 8'h28, d);
            bus(1'b1, 8'h2c, d2);
            bus(1'b1, 8'h30, 32'h1f);
            mk_x = (mk_x | d[4:0]) & ~d2[4:0];
            rd(8'h30, {27'h0, mk_x}, 32'hffffffff);
        end
        bus(1'b1, 8'h34, 32'h2);
        rd(8'h3c, 32'h2, 32'h2);
        `CHK("event", 1'b1, evo[1])
        bus(1'b1, 8'h38, 32'h2);
        `CHK("event", 1'b0, evo[1])
        bus(1'b1, 8'h20, 32'h1f);
        bus(1'b1, 8'h2c, 32'h1f);
        bus(1'b1, 8'h44, 32'h1f);
        bus(1'b1, 8'h24, DELAY_V);
        rd(8'h24, DELAY_V, 32'h3ff);
        bus(1'b1, 8'h28, 32'h09);
        bus(1'b1, 8'h1c, 32'h09);
        p = 0;
        n = 0;
        while (rdy[0] !== 1'b1 && n < 400)
        begin
            @(posedge mclk_in);
            n++;
            p += if_en;
        end
        `CHK("startup", 1'b1, (p >= DELAY_V - 1 && p <= DELAY_V + 2))
        `CHK("ready b", 1'b0, rdy[1])
        repeat (3) @(posedge mclk_in);
        `CHK("irq", 1'b1, irq)
        rd(8'h40, 32'h08, 32'h1f);
        bus(1'b1, 8'h44, 32'h08);
        repeat (2) @(posedge mclk_in);
        `CHK("irq", 1'b0, irq)
        fire <= 3'h1;
        @(posedge mclk_in);
        fire <= 3'h0;
        repeat (4) @(posedge mclk_in);
        `CHK("irq", 1'b1, irq)
        bus(1'b1, 8'h2c, 32'h01);
        repeat (2) @(posedge mclk_in);
        `CHK("irq", 1'b0, irq)
        bus(1'b1, 8'h1c, 32'h04);
        bus(1'b1, 8'h28, 32'h06);
        repeat (40) @(posedge mclk_in);
        `CHK("ready", 2'h3, rdy)
        bus(1'b1, 8'h44, 32'h1f);
        fire <= 3'h6;
        @(posedge mclk_in);
        fire <= 3'h0;
        repeat (4) @(posedge mclk_in);
        `CHK("irq", 1'b1, irq)
        rd(8'h40, 32'h07000006, 32'h0700001f);
        results();
    end
endmodule
